/* verilog/mcuim_irq_mux.sv */
// Purpose: Two-level priority interrupt source mux with vectored calls.
// Assumes: Peripheral events and core status come on clk; pins do not.
// Notes:   A call is a one-cycle pulse and counts as service entry.
`timescale 1ns/1ps
module mcuim_irq_mux
  import mcuim_pkg::*;
(
  input  wire logic             clk,                 // 200 MHz clock.
  input  wire logic             rst_n,               // Async reset, active low.
  input  wire logic [7:0]       avs_address,         // Byte address.
  input  wire logic             avs_read,            // Read request.
  input  wire logic             avs_write,           // Write request.
  input  wire logic [31:0]      avs_writedata,       // Write data.
  output logic      [31:0]      avs_readdata,        // Read data.
  output logic                  avs_waitrequest,     // Slave not ready.
  input  wire logic             ext_irq_pin_a,       // External input A pin.
  input  wire logic             ext_irq_pin_b,       // External input B pin.
  input  wire logic             timer_c_trigger_pin, // Timer C event pin.
  input  wire mcuim_periph_ev_s periph_ev,           // Peripheral events.
  input  wire mcuim_cpu_stat_s  cpu_stat,            // Core status.
  output logic                  irq_call,            // Call request pulse.
  output logic      [15:0]      irq_vector,          // Call target.
  output logic                  irq_high             // Call is high level.
);

  // ****************************************************************
  // Reset release
  // ****************************************************************
  logic [1:0] rst_sync_q;  // Reset release stages.
  logic       rst_loc_n;   // Synchronised reset.

  // Two-stage release of the asynchronous reset.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rst_sync_q <= 2'h0;
    end else begin
      rst_sync_q <= {rst_sync_q[0], 1'b1};
    end
  end
  assign rst_loc_n = rst_sync_q[1];

  // ****************************************************************
  // Pin synchronisers and edge detection
  // ****************************************************************
  logic [2:0] pin_s1_q;  // First stage, read only by second.
  logic [2:0] pin_s2_q;  // Second stage, usable level.
  logic [2:0] pin_s3_q;  // Previous level for edges.
  logic [2:0] pin_fall;  // Falling edge seen.

  // Pins idle high, so stages reset high to avoid a false edge.
  always_ff @(posedge clk or negedge rst_loc_n) begin
    if (!rst_loc_n) begin
      pin_s1_q <= 3'h7;
      pin_s2_q <= 3'h7;
      pin_s3_q <= 3'h7;
    end else begin
      pin_s1_q <= {timer_c_trigger_pin, ext_irq_pin_b, ext_irq_pin_a};
      pin_s2_q <= pin_s1_q;
      pin_s3_q <= pin_s2_q;
    end
  end
  assign pin_fall = pin_s3_q & ~pin_s2_q;

  // ****************************************************************
  // Bus slave
  // ****************************************************************
  logic [7:0]  ie_main_q, ie_main_d;  // Main enables, global in bit 7.
  logic [7:0]  ie_aux_q, ie_aux_d;    // Auxiliary enables.
  logic [7:0]  ip_main_q, ip_main_d;  // Main priorities.
  logic [7:0]  ip_aux_q, ip_aux_d;    // Auxiliary priorities.
  logic [1:0]  trig_q, trig_d;        // Trigger types, 1 selects edge.
  logic        waitreq_q, waitreq_d;  // Wait request.
  logic [31:0] rdata_q, rdata_d;      // Read data.
  logic        wr_go;                 // Write takes effect now.
  logic        cfg_wr;                // Enable/priority write now.
  logic [NUM_FLAGS-1:0] flags;        // Pending flags.
  logic [NUM_SRC-1:0]   sample_q;     // Sampled requests.
  mcuim_svc_e  svc_q, svc_d;          // Routines in progress.

  // Request seen with wait high drops wait; the next edge completes it.
  assign wr_go  = avs_write && !waitreq_q;
  assign cfg_wr = wr_go && (avs_address == OFS_IE_MAIN ||
                  avs_address == OFS_IE_AUX || avs_address == OFS_IP_MAIN ||
                  avs_address == OFS_IP_AUX);

  // Register writes, read mux and wait handshake.
  always_comb begin
    ie_main_d = ie_main_q;
    ie_aux_d  = ie_aux_q;
    ip_main_d = ip_main_q;
    ip_aux_d  = ip_aux_q;
    trig_d    = trig_q;
    rdata_d   = rdata_q;
    waitreq_d = !((avs_read || avs_write) && waitreq_q);
    if (wr_go) begin
      unique case (avs_address)
        OFS_IE_MAIN: ie_main_d = avs_writedata[7:0];
        OFS_IE_AUX:  ie_aux_d  = avs_writedata[7:0];
        OFS_IP_MAIN: ip_main_d = avs_writedata[7:0];
        OFS_IP_AUX:  ip_aux_d  = avs_writedata[7:0];
        OFS_TRIG:    trig_d    = avs_writedata[1:0];
        default:     ;  // Flags handled below, others ignored.
      endcase
    end
    if (avs_read && waitreq_q) begin
      unique case (avs_address)
        OFS_IE_MAIN: rdata_d = {24'h000000, ie_main_q};
        OFS_IE_AUX:  rdata_d = {24'h000000, ie_aux_q};
        OFS_IP_MAIN: rdata_d = {24'h000000, ip_main_q};
        OFS_IP_AUX:  rdata_d = {24'h000000, ip_aux_q};
        OFS_TRIG:    rdata_d = {30'h00000000, trig_q};
        OFS_FLAGS:   rdata_d = {4'h0, flags};
        OFS_SVC: begin
          rdata_d = '0;
          rdata_d[SVC_SAMPLE_LSB +: NUM_SRC] = sample_q;
          rdata_d[1] = (svc_q == SVC_HIGH) || (svc_q == SVC_BOTH);
          rdata_d[0] = (svc_q == SVC_LOW) || (svc_q == SVC_BOTH);
        end
        default: rdata_d = 32'h00000000;  // Unmapped reads zero.
      endcase
    end
  end

  // Bus registers.
  always_ff @(posedge clk or negedge rst_loc_n) begin
    if (!rst_loc_n) begin
      ie_main_q <= RST_IE;
      ie_aux_q  <= RST_IE;
      ip_main_q <= RST_IP;
      ip_aux_q  <= RST_IP;
      trig_q    <= RST_TRIG;
      waitreq_q <= 1'b1;
      rdata_q   <= 32'h00000000;
    end else begin
      ie_main_q <= ie_main_d;
      ie_aux_q  <= ie_aux_d;
      ip_main_q <= ip_main_d;
      ip_aux_q  <= ip_aux_d;
      trig_q    <= trig_d;
      waitreq_q <= waitreq_d;
      rdata_q   <= rdata_d;
    end
  end
  assign avs_waitrequest = waitreq_q;
  assign avs_readdata    = rdata_q;

  // ****************************************************************
  // Pending flags
  // ****************************************************************
  logic [NUM_FLAGS-1:0] flag_set;  // Hardware set pulses.
  logic [NUM_FLAGS-1:0] flag_clr;  // Hardware and software clears.
  logic                 fire;      // Call issued this cycle.
  logic [3:0]           win;       // Winning source.

  // Set and clear terms for every flag.
  always_comb begin
    flag_set = '0;
    flag_clr = '0;
    // Edge mode sets on a fall, level mode mirrors a low pin.
    flag_set[F_EXT0] = trig_q[0] ? pin_fall[0] : !pin_s2_q[0];
    flag_set[F_EXT1] = trig_q[1] ? pin_fall[1] : !pin_s2_q[1];
    flag_clr[F_EXT0] = !trig_q[0] && pin_s2_q[0];
    flag_clr[F_EXT1] = !trig_q[1] && pin_s2_q[1];
    flag_set[F_TA] = periph_ev.timer_a_ovf && !periph_ev.timer_a_mode3;
    flag_set[F_TB] = periph_ev.timer_b_ovf;
    flag_set[F_UA_RX] = periph_ev.uart_a_rx;
    flag_set[F_UA_TX] = periph_ev.uart_a_tx;
    flag_set[F_UB_RX] = periph_ev.uart_b_rx;
    flag_set[F_UB_TX] = periph_ev.uart_b_tx;
    flag_set[F_TC_OVF] = periph_ev.timer_c_ovf;
    flag_set[F_TC_EXT] = pin_fall[2];
    flag_set[F_SPI +: 4] = periph_ev.spi_ev;
    flag_set[F_USB +: 4] = periph_ev.usb_ev;
    flag_set[F_I2C] = |periph_ev.i2c_ev;
    flag_set[F_ADC] = periph_ev.adc_done;
    flag_set[F_PCA +: 8] = {periph_ev.cnt_ovf, periph_ev.cmp_ev};
    // Service entry clears only the self-clearing flags of the winner.
    if (fire) begin
      flag_clr = flag_clr | (SRC_FLAG_MASK[win] & FLAG_AUTO_CLR &
                 ~{{(NUM_FLAGS-2){1'b0}}, ~trig_q});
    end
    // Software writes ones to clear.
    if (wr_go && avs_address == OFS_FLAGS) begin
      flag_clr = flag_clr | avs_writedata[NUM_FLAGS-1:0];
    end
  end

  mcuim_flag_bank #(
    .WIDTH (NUM_FLAGS)
  ) u_flags (
    .clk   (clk),
    .rst_n (rst_loc_n),
    .set   (flag_set),
    .clr   (flag_clr),
    .flags (flags)
  );

  // ****************************************************************
  // Request forming
  // ****************************************************************
  logic [NUM_SRC-1:0] src_req;  // Enabled requests per source.
  logic [NUM_SRC-1:0] src_pri;  // High level per source.

  // Each source ORs its flags, gated by its enable and the global one.
  always_comb begin
    src_req = '0;
    src_pri = '0;
    for (int s = 1; s < NUM_SRC; s++) begin
      src_req[s] = (|(flags & SRC_FLAG_MASK[s])) &&
                   ie_main_q[GLOBAL_EN_BIT] &&
                   (SRC_CFG_POS[s][3] ? ie_aux_q[SRC_CFG_POS[s][2:0]]
                                      : ie_main_q[SRC_CFG_POS[s][2:0]]);
      src_pri[s] = SRC_CFG_POS[s][3] ? ip_aux_q[SRC_CFG_POS[s][2:0]]
                                     : ip_main_q[SRC_CFG_POS[s][2:0]];
    end
  end

  // ****************************************************************
  // Polling and call generation
  // ****************************************************************
  logic [NUM_SRC-1:0] sample_d;        // Next sample.
  logic [3:0]         hi_idx, lo_idx;  // Best per level.
  logic               hi_any, lo_any;  // Any sampled per level.
  logic               gate_ok;         // Instruction and bus allow a call.
  logic               return_from_irq_instr_done;       // Return completes now.
  logic               call_d, high_d;  // Next call outputs.
  logic [15:0]        vec_d;           // Next vector.
  logic               call_q, high_q;  // Call outputs.
  logic [15:0]        vec_q;           // Vector output.

  // Fresh sample every machine cycle start; old samples are dropped.
  always_comb begin
    sample_d = cpu_stat.cycle_start ? src_req : sample_q;
  end

  // Lowest index of each level wins, scanning downward.
  always_comb begin
    hi_idx = 4'h0;
    lo_idx = 4'h0;
    hi_any = 1'b0;
    lo_any = 1'b0;
    for (int s = NUM_SRC - 1; s >= 0; s--) begin
      if (sample_q[s] && src_pri[s]) begin
        hi_idx = 4'(s);
        hi_any = 1'b1;
      end
      if (sample_q[s] && !src_pri[s]) begin
        lo_idx = 4'(s);
        lo_any = 1'b1;
      end
    end
  end

  // Poll the previous sample at cycle start when the core allows it and no enable/priority bus write is under way.
  always_comb begin
    gate_ok = cpu_stat.last_cycle && !cpu_stat.sfr_write &&
              !cpu_stat.return_from_irq_instr_exec && !cfg_wr;
    return_from_irq_instr_done = cpu_stat.cycle_start && cpu_stat.last_cycle &&
                cpu_stat.return_from_irq_instr_exec;
    fire = 1'b0;
    high_d = 1'b0;
    win = lo_idx;
    if (cpu_stat.cycle_start && gate_ok) begin
      if (hi_any && svc_q != SVC_HIGH && svc_q != SVC_BOTH) begin
        fire = 1'b1;
        high_d = 1'b1;
        win = hi_idx;
      end else if (lo_any && svc_q == SVC_IDLE) begin
        fire = 1'b1;
      end
    end
    call_d = fire;
    vec_d = fire ? SRC_VECTOR[win] : vec_q;
  end

  // Track routines in progress; a return ends the innermost one.
  always_comb begin
    svc_d = svc_q;
    if (fire) begin
      svc_d = !high_d ? SVC_LOW : (svc_q == SVC_LOW ? SVC_BOTH : SVC_HIGH);
    end else if (return_from_irq_instr_done) begin
      unique case (svc_q)
        SVC_BOTH: svc_d = SVC_LOW;
        SVC_HIGH: svc_d = SVC_IDLE;
        SVC_LOW:  svc_d = SVC_IDLE;
        SVC_IDLE: svc_d = SVC_IDLE;
      endcase
    end
  end

  // Polling and call registers.
  always_ff @(posedge clk or negedge rst_loc_n) begin
    if (!rst_loc_n) begin
      sample_q <= '0;
      svc_q    <= SVC_IDLE;
      call_q   <= 1'b0;
      high_q   <= 1'b0;
      vec_q    <= 16'h0000;
    end else begin
      sample_q <= sample_d;
      svc_q    <= svc_d;
      call_q   <= call_d;
      high_q   <= call_d ? high_d : high_q;
      vec_q    <= vec_d;
    end
  end
  assign irq_call   = call_q;
  assign irq_vector = vec_q;
  assign irq_high   = high_q;

endmodule // mcuim_irq_mux

/* verilog/mcuim_pkg.sv */
// Purpose: Shared constants and carriers for the interrupt source mux.
// Assumes: Avalon-MM byte addresses, one 32-bit word per register.
// Notes:   Source index equals polling order, 0 is the highest.
package mcuim_pkg;

  // ****************************************************************
  // Sizes
  // ****************************************************************
  localparam int NUM_SRC   = 13;  // Polling slots, slot 0 reserved.
  localparam int NUM_FLAGS = 28;  // Pending flags held in the block.

  // ****************************************************************
  // Register offsets and reset values
  // ****************************************************************
  localparam logic [7:0] OFS_IE_MAIN = 8'ha8;  // Main enable register.
  localparam logic [7:0] OFS_IE_AUX  = 8'hac;  // Auxiliary enables.
  localparam logic [7:0] OFS_IP_MAIN = 8'hb0;  // Main priority register.
  localparam logic [7:0] OFS_IP_AUX  = 8'hb4;  // Auxiliary priorities.
  localparam logic [7:0] OFS_TRIG    = 8'hb8;  // External trigger types.
  localparam logic [7:0] OFS_FLAGS   = 8'hbc;  // Pending flags, W1C.
  localparam logic [7:0] OFS_SVC     = 8'hc0;  // Service state, RO.
  localparam logic [7:0] RST_IE      = 8'h00;  // Enable reset value.
  localparam logic [7:0] RST_IP      = 8'h00;  // Priority reset value.
  localparam logic [1:0] RST_TRIG    = 2'h0;   // Both inputs level mode.

  // ****************************************************************
  // Field positions
  // ****************************************************************
  localparam int GLOBAL_EN_BIT = 7;   // Global enable in main enables.
  localparam int SVC_SAMPLE_LSB = 8;  // Sampled requests in service reg.
  localparam int F_EXT0   = 0;        // External input A pending.
  localparam int F_EXT1   = 1;        // External input B pending.
  localparam int F_TA     = 2;        // Timer A overflow.
  localparam int F_TB     = 3;        // Timer B overflow.
  localparam int F_UA_RX  = 4;        // UART A received.
  localparam int F_UA_TX  = 5;        // UART A transmitted.
  localparam int F_TC_OVF = 6;        // Timer C overflow.
  localparam int F_TC_EXT = 7;        // Timer C external event.
  localparam int F_SPI    = 8;        // Four SPI flags from here.
  localparam int F_USB    = 12;       // Four USB group flags from here.
  localparam int F_I2C    = 16;       // I2C pending.
  localparam int F_ADC    = 17;       // Converter done.
  localparam int F_PCA    = 18;       // Six compare, two counter flags.
  localparam int F_UB_RX  = 26;       // UART B received.
  localparam int F_UB_TX  = 27;       // UART B transmitted.

  // Enable/priority location per source: bit 3 picks aux, [2:0] bit.
  localparam logic [3:0] SRC_CFG_POS [NUM_SRC] = '{
    4'h0, 4'h0, 4'h1, 4'h2, 4'h3, 4'h4, 4'h5,
    4'he, 4'h8, 4'h9, 4'hf, 4'hd, 4'hc};
  // Call target per source.
  localparam logic [15:0] SRC_VECTOR [NUM_SRC] = '{
    16'h0063, 16'h0003, 16'h000b, 16'h0013, 16'h001b, 16'h0023, 16'h002b,
    16'h0053, 16'h0033, 16'h0043, 16'h003b, 16'h005b, 16'h004b};
  // Flags that feed each source.
  localparam logic [NUM_FLAGS-1:0] SRC_FLAG_MASK [NUM_SRC] = '{
    28'h0000000, 28'h0000001, 28'h0000004, 28'h0000002, 28'h0000008,
    28'h0000030, 28'h00000c0, 28'h0000f00, 28'h000f000, 28'h0010000,
    28'h0020000, 28'h3fc0000, 28'hc000000};
  // Flags cleared by hardware on service entry (external ones edge only).
  localparam logic [NUM_FLAGS-1:0] FLAG_AUTO_CLR = 28'h0010f0f;

  // ****************************************************************
  // Types
  // ****************************************************************
  // Event pulses and mode levels from the peripherals, same clock.
  typedef struct packed {
    logic       timer_a_ovf;
    logic       timer_a_mode3;
    logic       timer_b_ovf;
    logic       timer_c_ovf;
    logic       uart_a_rx;
    logic       uart_a_tx;
    logic       uart_b_rx;
    logic       uart_b_tx;
    logic [3:0] spi_ev;   // End, overrun, tx empty, rx full.
    logic [3:0] usb_ev;   // Global, in empty, out full, in not ready.
    logic [3:0] i2c_ev;   // Own address, general call, stop, byte.
    logic       adc_done;
    logic [5:0] cmp_ev;   // Compare module match or capture.
    logic [1:0] cnt_ovf;  // Counter overflows.
  } mcuim_periph_ev_s;

  // Core status, same clock.
  typedef struct packed {
    logic cycle_start;  // One-cycle pulse at each machine cycle start.
    logic last_cycle;   // Current machine cycle ends its instruction.
    logic sfr_write;    // Instruction writes an enable/priority register.
    logic return_from_irq_instr_exec;    // Instruction is a return from interrupt.
  } mcuim_cpu_stat_s;

  // Routines in progress.
  typedef enum logic [1:0] {SVC_IDLE, SVC_LOW, SVC_HIGH, SVC_BOTH} mcuim_svc_e;

endpackage

/* verilog/mcuim_flag_bank.sv */
// Purpose: Bank of sticky pending flags with set and clear vectors.
// Assumes: Set and clear are synchronous to clk.
// Notes:   A set in the same cycle as a clear wins.
`timescale 1ns/1ps
module mcuim_flag_bank #(
  parameter int WIDTH = 28  // Number of flags.
) (
  input  wire logic             clk,    // System clock.
  input  wire logic             rst_n,  // Synchronised reset, active low.
  input  wire logic [WIDTH-1:0] set,    // Set pulses.
  input  wire logic [WIDTH-1:0] clr,    // Clear pulses.
  output logic      [WIDTH-1:0] flags   // Flag state.
);

  // ****************************************************************
  // Elaboration check
  // ****************************************************************
  if (WIDTH < 1) begin : g_chk
    $error("flag bank needs at least one flag");
  end

  logic [WIDTH-1:0] flags_d;  // Next flag state.

  // Set has priority so no event is lost during a clear.
  always_comb begin
    flags_d = set | (flags & ~clr);
  end

  // Flag registers.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      flags <= '0;
    end else begin
      flags <= flags_d;
    end
  end

endmodule // mcuim_flag_bank

/* tb/mcuim_cpu_model.sv */
// Purpose: Core model that drives the machine-cycle status into the mux.
// Assumes: Four clocks to a machine cycle; bench holds levels a whole cycle.
// Notes:   Each status level is the bench request delayed by one clock.
`timescale 1ns/1ps
module mcuim_cpu_model
  import mcuim_pkg::*;
(
  input  wire logic       clk,        // System clock.
  input  wire logic       rst_n,      // Reset, active low.
  input  wire logic       mid_instr,  // Instruction does not end this cycle.
  input  wire logic       cfg_wr,     // Instruction writes enable or priority.
  input  wire logic       return_from_irq_instr_req,   // Instruction is a return from routine.
  output mcuim_cpu_stat_s stat        // Status seen by the mux.
);
  logic [1:0] cnt_q;  // Clock within the machine cycle.
  logic [1:0] cnt_d;  // Next clock count.
  // The count wraps every four clocks.
  always_comb cnt_d = cnt_q + 2'h1;
  always_ff @(posedge clk or negedge rst_n)
    if (!rst_n) cnt_q <= 2'h0;
    else cnt_q <= cnt_d;
  // One start pulse per machine cycle; levels follow the bench.
  always_ff @(posedge clk or negedge rst_n)
    if (!rst_n) stat <= '0;
    else stat <= '{(cnt_d == 2'h0), !mid_instr, cfg_wr, return_from_irq_instr_req};
endmodule  // mcuim_cpu_model

/* tb/mcuim_irq_mux_chk.sv */
// Purpose: Port-level checks of the interrupt source mux.
// Assumes: Bound to the top module; one clock domain.
// Notes:   Helper flags mirror the global enable and routines in progress.
`timescale 1ns/1ps
module mcuim_irq_mux_chk
  import mcuim_pkg::*;
(
  input wire logic            clk,              // System clock.
  input wire logic            rst_n,            // Reset, active low.
  input wire logic [7:0]      avs_address,      // Byte address.
  input wire logic            avs_read,         // Read request.
  input wire logic            avs_write,        // Write request.
  input wire logic [31:0]     avs_writedata,    // Write data.
  input wire logic            avs_waitrequest,  // Slave not ready.
  input wire mcuim_cpu_stat_s cpu_stat,         // Core status.
  input wire logic            irq_call,         // Call pulse.
  input wire logic [15:0]     irq_vector,       // Call target.
  input wire logic            irq_high          // Call level.
);
  logic ge_q, hi_q, lo_q;  // Global enable, high and low routine active.
  wire  ends = cpu_stat.cycle_start && cpu_stat.last_cycle && cpu_stat.return_from_irq_instr_exec;
  // A return ends the innermost routine; a call opens one.
  always_ff @(posedge clk or negedge rst_n)
    if (!rst_n) {ge_q, hi_q, lo_q} <= 3'h0;
    else begin
      if (avs_write && !avs_waitrequest && avs_address == OFS_IE_MAIN) ge_q <= avs_writedata[GLOBAL_EN_BIT];
      if (irq_call && irq_high) hi_q <= 1'b1;
      else if (irq_call) lo_q <= 1'b1;
      else if (ends && hi_q) hi_q <= 1'b0;
      else if (ends) lo_q <= 1'b0;
    end
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  property p_wait_one; (avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest; endproperty
  property p_wait_pulse; !avs_waitrequest |=> avs_waitrequest; endproperty
  property p_call_pulse; irq_call |=> !irq_call; endproperty
  property p_call_poll; irq_call |-> $past(cpu_stat.cycle_start); endproperty
  property p_gate; cpu_stat.cycle_start && (!cpu_stat.last_cycle || cpu_stat.return_from_irq_instr_exec || cpu_stat.sfr_write)
    |=> !irq_call; endproperty
  property p_vector; irq_call |-> irq_vector inside {16'h0003, 16'h000b, 16'h0013, 16'h001b,
    16'h0023, 16'h002b, 16'h0053, 16'h0033, 16'h0043, 16'h003b, 16'h005b, 16'h004b}; endproperty
  property p_global; irq_call |-> ge_q; endproperty
  property p_level; irq_call |-> !hi_q && (irq_high || !lo_q); endproperty
  property p_hold; !irq_call |-> $stable(irq_vector) && $stable(irq_high); endproperty
  a_wait_one: assert property (p_wait_one) else $error("bus request not answered in one cycle");
  a_wait_pulse: assert property (p_wait_pulse) else $error("waitrequest low too long");
  a_call_pulse: assert property (p_call_pulse) else $error("call longer than one cycle");
  a_call_poll: assert property (p_call_poll) else $error("call not after a poll");
  a_gate: assert property (p_gate) else $error("call during a blocked cycle");
  a_vector: assert property (p_vector) else $error("illegal vector");
  a_global: assert property (p_global) else $error("call with global enable clear");
  a_level: assert property (p_level) else $error("call at equal or lower level");
  a_hold: assert property (p_hold) else $error("vector changed without call");
  c_high: cover property (irq_call && irq_high);
  c_low: cover property (irq_call && !irq_high);
  c_read: cover property (avs_read && !avs_waitrequest);
endmodule  // mcuim_irq_mux_chk
bind mcuim_irq_mux mcuim_irq_mux_chk u_chk (.clk, .rst_n, .avs_address, .avs_read, .avs_write,
  .avs_writedata, .avs_waitrequest, .cpu_stat, .irq_call, .irq_vector, .irq_high);

/* tb/mcuim_irq_mux_test.sv */
// Purpose: Self-checking bench of the interrupt source mux.
// Assumes: Core model drives status; bench drives bus, pins and events.
// Notes:   Fixed seed; every source, ties, preemption and gating.
`timescale 1ns/1ps
module mcuim_irq_mux_test
  import mcuim_pkg::*;
;
  logic clk = 1'b0, rst_n = 1'b0, rd_en = 1'b0, wr_en = 1'b0, pa = 1'b1, pb = 1'b1, pc = 1'b1;
  logic mid = 1'b0, cfgw = 1'b0, return_from_irq_instr = 1'b0, call, high, wreq;
  logic [7:0] addr = 8'h00;
  logic [31:0] wdata = 32'h0, rdata, rv;
  logic [15:0] vec;
  mcuim_periph_ev_s ev = '0;
  mcuim_cpu_stat_s stat;
  int err_total = 0, n_tests = 0, seed = 30887, s;
  mcuim_cpu_model core (.clk(clk), .rst_n(rst_n), .mid_instr(mid), .cfg_wr(cfgw), .return_from_irq_instr_req(return_from_irq_instr), .stat(stat));
  mcuim_irq_mux uut (.clk(clk), .rst_n(rst_n), .avs_address(addr), .avs_read(rd_en), .avs_write(wr_en),
    .avs_writedata(wdata), .avs_readdata(rdata), .avs_waitrequest(wreq), .ext_irq_pin_a(pa),
    .ext_irq_pin_b(pb), .timer_c_trigger_pin(pc), .periph_ev(ev), .cpu_stat(stat), .irq_call(call),
    .irq_vector(vec), .irq_high(high));
  initial forever #2.5 clk = ~clk;
  initial begin #400000; err_total++; test_done(); end
  // Slots whose flags the mux clears itself on service entry.
  function automatic logic auto_clr(input int k);
    return k inside {1, 2, 3, 4, 7, 9};
  endfunction
  task automatic test_done;
    $display("comparisons %0d mismatches %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      err_total++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // Holds the request until waitrequest is seen low at a rising edge.
  task automatic bus(input logic we, input logic [7:0] a, input logic [31:0] d);
    int i = 0;
    @(posedge clk);
    rd_en <= !we; wr_en <= we; addr <= a; wdata <= d;
    do begin @(posedge clk); i++; end while (wreq && i < 50);
    if (wreq) begin err_total++; test_done(); end
    rv = rdata;
    rd_en <= 1'b0; wr_en <= 1'b0;
  endtask
  task automatic wcall(input logic [15:0] v, input logic h);
    int i = 0;
    do begin @(negedge clk); i++; end while (call !== 1'b1 && i < 200);
    chk({call, high, vec}, {1'b1, h, v});
    if (call !== 1'b1) test_done();
  endtask
  task automatic quiet(input int n);
    repeat (n) begin @(negedge clk); chk(call, 0); end
  endtask
  task automatic ret;
    @(posedge clk); return_from_irq_instr <= 1'b1;
    repeat (4) @(posedge clk); return_from_irq_instr <= 1'b0;
  endtask
  // One-cycle event pulses, pin falls held five clocks, per slot in the mask.
  task automatic fire(input logic [12:0] m, input logic [7:0] r);
    @(posedge clk);
    for (int k = 1; k < 13; k++)
      if (m[k])
        case (k)
          1: pa <= 1'b0;
          2: ev.timer_a_ovf <= 1'b1;
          3: pb <= 1'b0;
          4: ev.timer_b_ovf <= 1'b1;
          5: {ev.uart_a_rx, ev.uart_a_tx} <= r[0] ? 2'h1 : 2'h2;
          6: if (r[0]) ev.timer_c_ovf <= 1'b1; else pc <= 1'b0;
          7: ev.spi_ev <= 4'h1 << r[1:0];
          8: ev.usb_ev <= 4'h1 << r[1:0];
          9: ev.i2c_ev <= 4'h1 << r[1:0];
          10: ev.adc_done <= 1'b1;
          11: {ev.cmp_ev, ev.cnt_ovf} <= 8'h1 << r[2:0];
          default: {ev.uart_b_rx, ev.uart_b_tx} <= r[0] ? 2'h1 : 2'h2;
        endcase
    @(posedge clk);
    ev <= '0;
    repeat (4) @(posedge clk);
    {pa, pb, pc} <= 3'h7;
  endtask
  initial begin
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    repeat (3) @(posedge clk);
    bus(0, OFS_IE_MAIN, 0); chk(rv, RST_IE);
    bus(0, 8'hc4, 0); chk(rv, 0);
    bus(1, OFS_IE_MAIN, 32'hbf); bus(0, OFS_IE_MAIN, 0); chk(rv, 32'hbf);
    bus(1, OFS_IE_AUX, 32'hf3); bus(1, OFS_TRIG, 32'h3);
    // Each source alone, first held off by a long instruction (odd slots) or a config write (even slots).
    for (s = 1; s < 13; s++) begin
      mid <= s[0];
      cfgw <= !s[0];
      fire(13'h1 << s, 8'($random(seed)));
      quiet(16);
      mid <= 1'b0;
      cfgw <= 1'b0;
      wcall(SRC_VECTOR[s], 0);
      bus(0, OFS_FLAGS, 0);
      chk(|(rv & SRC_FLAG_MASK[s]), !auto_clr(s));
      bus(1, OFS_FLAGS, 32'h0fffffff);
      ret;
    end
    // Tie at low level, then high preempts and low waits.
    bus(1, OFS_IP_AUX, 32'h10);
    fire(13'h24, 8'($random(seed)));
    wcall(16'h000b, 0);
    fire(13'h1000, 8'($random(seed)));
    wcall(16'h004b, 1);
    bus(0, OFS_SVC, 0);
    chk(rv[1:0], 2'h3);
    bus(1, OFS_FLAGS, 32'h0c000000);
    ret; quiet(12); ret;
    wcall(16'h0023, 0);
    bus(1, OFS_FLAGS, 32'h0fffffff); ret;
    // Global enable clear masks a pending source.
    bus(1, OFS_IE_MAIN, 32'h3f);
    fire(13'h4, 8'($random(seed))); quiet(20);
    bus(1, OFS_IE_MAIN, 32'hbf); wcall(16'h000b, 0); ret;
    // Timer A in its third mode raises no flag.
    @(posedge clk); ev.timer_a_ovf <= 1'b1; ev.timer_a_mode3 <= 1'b1;
    @(posedge clk); ev <= '0;
    quiet(12); bus(0, OFS_FLAGS, 0); chk(rv[F_TA], 0);
    // Level mode: the flag follows the pin, not service entry.
    bus(1, OFS_TRIG, 32'h0); @(posedge clk); pa <= 1'b0;
    wcall(16'h0003, 0); bus(0, OFS_FLAGS, 0); chk(rv[F_EXT0], 1);
    pa <= 1'b1; quiet(12); ret; bus(0, OFS_FLAGS, 0); chk(rv[F_EXT0], 0);
    test_done();
  end
endmodule  // mcuim_irq_mux_test
